// file: hw/wecs_defines.vh
// Constants for the wake and event capture block: register offsets,
// field positions, reset values and mode codes.
// Assumes inclusion by bare name from each design file that needs it.
`ifndef WECS_DEFINES_VH
`define WECS_DEFINES_VH

// ==========================================================
// Register offsets (7-bit register address)
`define WECS_ADDR_SYS_EN 7'h04
`define WECS_ADDR_TRX_EN 7'h23
`define WECS_ADDR_BF_EN 7'h32
`define WECS_ADDR_WK_EN 7'h4c
`define WECS_ADDR_SUMMARY 7'h60
`define WECS_ADDR_SYS_ST 7'h61
`define WECS_ADDR_TRX_ST 7'h63
`define WECS_ADDR_WK_ST 7'h64
`define WECS_ADDR_BF_ST 7'h65
`define WECS_ADDR_DEV_ID 7'h7e

// ==========================================================
// Field positions of status and enable registers
`define WECS_SYS_PWRON 4
`define WECS_SYS_THERM 2
`define WECS_SYS_SERIAL 1
`define WECS_TRX_FRAME_ERR 5
`define WECS_TRX_BUS_WAKE 4
`define WECS_TRX_SILENCE 3
`define WECS_TRX_FAULT 0
`define WECS_BF_DOM_TOUT 1
`define WECS_BF_REC_CLAMP 0
`define WECS_WK_RISE 1
`define WECS_WK_FALL 0
`define WECS_SUM_SYS 0
`define WECS_SUM_TRX 1
`define WECS_SUM_BF 2
`define WECS_SUM_WK 3

// Writable bits of each enable register
`define WECS_SYS_EN_MASK 8'h06
`define WECS_TRX_EN_MASK 8'h19
`define WECS_BF_EN_MASK 8'h03
`define WECS_WK_EN_MASK 8'h03

// ==========================================================
// Reset values
`define WECS_EN_RESET 8'h00
`define WECS_ZERO_BYTE 8'h00

// ==========================================================
// Device mode codes and transceiver supply-check mode
`define WECS_MODE_SLEEP 3'h1
`define WECS_MODE_STANDBY 3'h4
`define WECS_MODE_NORMAL 3'h7
`define WECS_TRX_MODE_UV 2'h1

// Valid serial clock counts per frame
`define WECS_SPI_CNT_A 6'h10
`define WECS_SPI_CNT_B 6'h18
`define WECS_SPI_CNT_C 6'h20

`endif

// file: hw/wecs_event_latch.v
// One event status register: sticky, write-one-to-clear bits.
// Assumes event pulses and clear masks synchronous to the clock.
`timescale 1ns/1ns

module wecs_event_latch #(
    parameter WIDTH = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire [WIDTH-1:0] event_i,
    input wire [WIDTH-1:0] enable_i,
    input wire [WIDTH-1:0] clear_i,
    output wire [WIDTH-1:0] status_o,
    output wire captured_o,
    output wire cleared_o
);
    reg [WIDTH-1:0] status_q;
    wire [WIDTH-1:0] set_w;

    assign set_w = event_i & enable_i;
    assign status_o = status_q;
    assign captured_o = |set_w;
    assign cleared_o = |(clear_i & status_q);

    // ==========================================================
    // Per-bit latch; a set in the clearing cycle wins
    genvar b;
    generate
        for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
            always @(posedge clk_i) begin
                if (rst_i) begin
                    status_q[b] <= 1'b0;
                end else if (set_w[b]) begin
                    status_q[b] <= 1'b1;
                end else if (clear_i[b]) begin
                    status_q[b] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule

// file: hw/wecs_delay_timer.v
// Event delay timer: counts down from a load value, restartable.
// Assumes a one-cycle start pulse.
`timescale 1ns/1ns

module wecs_delay_timer #(
    parameter CYCLES = 1000,
    parameter WIDTH = 16
) (
    input wire clk_i,
    input wire rst_i,
    input wire start_i,
    output wire busy_o
);
    reg [WIDTH-1:0] count_q;

    assign busy_o = (count_q != {WIDTH{1'b0}});

    always @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= {WIDTH{1'b0}};
        end else if (start_i) begin
            count_q <= CYCLES[WIDTH-1:0];
        end else if (busy_o) begin
            count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule

// file: hw/wecs_top.v
// Wake and event capture: latches wake-up and interrupt events, signals
// them on the receive-data pin or the inhibit output, guards sleep entry.
// Assumes a serial-port decoder presenting a byte register port and
// event detectors giving one-cycle pulses, all on SYS_CLK_I.
`timescale 1ns/1ns
`include "wecs_defines.vh"

module wecs_top #(
    parameter EVENT_DELAY_CYCLES = 1000,
    parameter DELAY_WIDTH = 16,
    // Arbitrary identification value
    parameter [7:0] DEVICE_IDENTIFICATION = 8'h5a
) (
    input wire SYS_CLK_I,
    input wire RESET_I,
    input wire [6:0] REG_ADDR_I,
    input wire REG_WR_I,
    input wire REG_RD_I,
    input wire [7:0] REG_WDATA_I,
    input wire MODE_REQ_VALID_I,
    input wire [2:0] MODE_REQ_I,
    input wire SPI_FRAME_DONE_I,
    input wire [5:0] SPI_CLK_COUNT_I,
    input wire LOCKED_WRITE_I,
    input wire BATTERY_SUPPLY_OK_I,
    input wire IO_SUPPLY_OK_I,
    input wire TRX_STANDBY_I,
    input wire TRX_ACTIVE_I,
    input wire [1:0] TRX_MODE_SELECT_I,
    input wire BUS_WAKE_I,
    input wire WAKE_PIN_I,
    input wire TEMP_WARN_I,
    input wire FRAME_ERR_OVF_I,
    input wire BUS_SILENCE_I,
    input wire TXD_DOM_TIMEOUT_I,
    input wire VCC_UNDERVOLT_I,
    input wire RXD_REC_CLAMP_I,
    input wire BUS_DOM_TIMEOUT_I,
    input wire BUS_REC_CLAMP_I,
    output reg [7:0] REG_RDATA_O,
    output reg [2:0] DEVICE_MODE_O,
    output reg RXD_LOW_O,
    output reg INHIBIT_O
);
    // ==========================================================
    // Device mode state
    localparam ST_SLEEP = 3'b001;
    localparam ST_STANDBY = 3'b010;
    localparam ST_NORMAL = 3'b100;

    reg [2:0] mode_q;
    reg [2:0] mode_d;
    wire in_sleep;
    wire in_normal;

    assign in_sleep = mode_q[0];
    assign in_normal = mode_q[2];

    // ==========================================================
    // Enable registers and edge history
    reg [7:0] sys_en_q;
    reg [7:0] trx_en_q;
    reg [7:0] bf_en_q;
    reg [7:0] wk_en_q;
    reg por_q;
    reg battery_prev_q;
    reg wake_prev_q;
    reg wake_prev_valid_q;
    reg temp_prev_q;

    // ==========================================================
    // Register port decode
    wire wr_sys_en = REG_WR_I && (REG_ADDR_I == `WECS_ADDR_SYS_EN);
    wire wr_trx_en = REG_WR_I && (REG_ADDR_I == `WECS_ADDR_TRX_EN);
    wire wr_bf_en = REG_WR_I && (REG_ADDR_I == `WECS_ADDR_BF_EN);
    wire wr_wk_en = REG_WR_I && (REG_ADDR_I == `WECS_ADDR_WK_EN);
    wire [7:0] clr_sys = REG_WDATA_I & {8{REG_WR_I && (REG_ADDR_I == `WECS_ADDR_SYS_ST)}};
    wire [7:0] clr_trx = REG_WDATA_I & {8{REG_WR_I && (REG_ADDR_I == `WECS_ADDR_TRX_ST)}};
    wire [7:0] clr_bf = REG_WDATA_I & {8{REG_WR_I && (REG_ADDR_I == `WECS_ADDR_BF_ST)}};
    wire [7:0] clr_wk = REG_WDATA_I & {8{REG_WR_I && (REG_ADDR_I == `WECS_ADDR_WK_ST)}};

    // ==========================================================
    // Event qualification
    wire spi_count_bad = SPI_FRAME_DONE_I && (SPI_CLK_COUNT_I != `WECS_SPI_CNT_A)
        && (SPI_CLK_COUNT_I != `WECS_SPI_CNT_B) && (SPI_CLK_COUNT_I != `WECS_SPI_CNT_C);
    wire mode_code_bad = MODE_REQ_VALID_I && (MODE_REQ_I != `WECS_MODE_SLEEP)
        && (MODE_REQ_I != `WECS_MODE_STANDBY) && (MODE_REQ_I != `WECS_MODE_NORMAL);
    wire ev_serial = ~in_sleep && (spi_count_bad || mode_code_bad || LOCKED_WRITE_I);
    wire ev_pwron = por_q || (BATTERY_SUPPLY_OK_I && ~battery_prev_q);
    wire ev_therm = in_normal && TEMP_WARN_I && ~temp_prev_q;
    wire ev_trx_fault = ~in_sleep && (TXD_DOM_TIMEOUT_I
        || (VCC_UNDERVOLT_I && (TRX_MODE_SELECT_I == `WECS_TRX_MODE_UV))
        || (RXD_REC_CLAMP_I && TRX_ACTIVE_I));
    wire ev_dom = ~in_sleep && BUS_DOM_TIMEOUT_I;
    wire ev_rec = ~in_sleep && BUS_REC_CLAMP_I;
    wire ev_rise = wake_prev_valid_q && WAKE_PIN_I && ~wake_prev_q;
    wire ev_fall = wake_prev_valid_q && ~WAKE_PIN_I && wake_prev_q;

    wire [7:0] sys_ev;
    wire [7:0] trx_ev;
    wire [7:0] bf_ev;
    wire [7:0] wk_ev;
    wire [7:0] sys_cap_en;
    wire [7:0] trx_cap_en;

    assign sys_ev = ({7'h00, ev_pwron} << `WECS_SYS_PWRON) | ({7'h00, ev_therm} << `WECS_SYS_THERM)
        | ({7'h00, ev_serial} << `WECS_SYS_SERIAL);
    assign trx_ev = ({7'h00, FRAME_ERR_OVF_I} << `WECS_TRX_FRAME_ERR)
        | ({7'h00, BUS_WAKE_I} << `WECS_TRX_BUS_WAKE)
        | ({7'h00, BUS_SILENCE_I} << `WECS_TRX_SILENCE)
        | ({7'h00, ev_trx_fault} << `WECS_TRX_FAULT);
    assign bf_ev = ({7'h00, ev_dom} << `WECS_BF_DOM_TOUT) | ({7'h00, ev_rec} << `WECS_BF_REC_CLAMP);
    assign wk_ev = ({7'h00, ev_rise} << `WECS_WK_RISE) | ({7'h00, ev_fall} << `WECS_WK_FALL);
    // Power-on and frame-error overflow cannot be masked
    assign sys_cap_en = sys_en_q | (8'h01 << `WECS_SYS_PWRON);
    assign trx_cap_en = trx_en_q | (8'h01 << `WECS_TRX_FRAME_ERR);

    // ==========================================================
    // Status registers
    wire [7:0] sys_st;
    wire [7:0] trx_st;
    wire [7:0] bf_st;
    wire [7:0] wk_st;
    wire cap_sys;
    wire cap_trx;
    wire cap_bf;
    wire cap_wk;
    wire clr_hit_sys;
    wire clr_hit_trx;
    wire clr_hit_bf;
    wire clr_hit_wk;

    wecs_event_latch #(.WIDTH(8)) u_sys (
        .clk_i(SYS_CLK_I),
        .rst_i(RESET_I),
        .event_i(sys_ev),
        .enable_i(sys_cap_en),
        .clear_i(clr_sys),
        .status_o(sys_st),
        .captured_o(cap_sys),
        .cleared_o(clr_hit_sys)
    );

    wecs_event_latch #(.WIDTH(8)) u_trx (
        .clk_i(SYS_CLK_I),
        .rst_i(RESET_I),
        .event_i(trx_ev),
        .enable_i(trx_cap_en),
        .clear_i(clr_trx),
        .status_o(trx_st),
        .captured_o(cap_trx),
        .cleared_o(clr_hit_trx)
    );

    wecs_event_latch #(.WIDTH(8)) u_bf (
        .clk_i(SYS_CLK_I),
        .rst_i(RESET_I),
        .event_i(bf_ev),
        .enable_i(bf_en_q),
        .clear_i(clr_bf),
        .status_o(bf_st),
        .captured_o(cap_bf),
        .cleared_o(clr_hit_bf)
    );

    wecs_event_latch #(.WIDTH(8)) u_wk (
        .clk_i(SYS_CLK_I),
        .rst_i(RESET_I),
        .event_i(wk_ev),
        .enable_i(wk_en_q),
        .clear_i(clr_wk),
        .status_o(wk_st),
        .captured_o(cap_wk),
        .cleared_o(clr_hit_wk)
    );

    wire any_capture = cap_sys | cap_trx | cap_bf | cap_wk;
    wire any_clear = clr_hit_sys | clr_hit_trx | clr_hit_bf | clr_hit_wk;
    wire [7:0] summary;
    assign summary = ({7'h00, |sys_st} << `WECS_SUM_SYS) | ({7'h00, |trx_st} << `WECS_SUM_TRX)
        | ({7'h00, |bf_st} << `WECS_SUM_BF) | ({7'h00, |wk_st} << `WECS_SUM_WK);
    wire pending = |summary;

    // ==========================================================
    // Event delay timer
    wire delay_busy;

    wecs_delay_timer #(.CYCLES(EVENT_DELAY_CYCLES), .WIDTH(DELAY_WIDTH)) u_delay (
        .clk_i(SYS_CLK_I),
        .rst_i(RESET_I),
        .start_i(any_clear),
        .busy_o(delay_busy)
    );

    // ==========================================================
    // Mode control and sleep guard
    wire wake_src_enabled = trx_en_q[`WECS_TRX_BUS_WAKE] | wk_en_q[`WECS_WK_RISE] | wk_en_q[`WECS_WK_FALL];
    // A capture in the request cycle also blocks sleep, else it would be missed
    wire sleep_ok = wake_src_enabled && ~pending && ~any_capture;

    always @* begin
        mode_d = mode_q;
        case (mode_q)
            ST_SLEEP: begin
                if (any_capture) begin
                    mode_d = ST_STANDBY;
                end else if (MODE_REQ_VALID_I && (MODE_REQ_I == `WECS_MODE_STANDBY)) begin
                    mode_d = ST_STANDBY;
                end else if (MODE_REQ_VALID_I && (MODE_REQ_I == `WECS_MODE_NORMAL)) begin
                    mode_d = ST_NORMAL;
                end
            end
            ST_STANDBY, ST_NORMAL: begin
                if (MODE_REQ_VALID_I) begin
                    case (MODE_REQ_I)
                        `WECS_MODE_SLEEP: mode_d = sleep_ok ? ST_SLEEP : ST_STANDBY;
                        `WECS_MODE_STANDBY: mode_d = ST_STANDBY;
                        `WECS_MODE_NORMAL: mode_d = ST_NORMAL;
                        default: mode_d = mode_q;
                    endcase
                end
            end
            default: mode_d = ST_STANDBY;
        endcase
    end

    // ==========================================================
    // Pin signalling: held off while the timer batches new events
    wire signal_state = TRX_STANDBY_I || ~in_normal;
    wire rxd_low_d = IO_SUPPLY_OK_I && signal_state && pending && ~delay_busy && ~any_clear;

    always @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            mode_q <= ST_STANDBY;
            DEVICE_MODE_O <= `WECS_MODE_STANDBY;
            INHIBIT_O <= 1'b1;
            RXD_LOW_O <= 1'b0;
        end else begin
            mode_q <= mode_d;
            DEVICE_MODE_O <= mode_d[0] ? `WECS_MODE_SLEEP : (mode_d[2] ? `WECS_MODE_NORMAL : `WECS_MODE_STANDBY);
            INHIBIT_O <= ~mode_d[0];
            RXD_LOW_O <= rxd_low_d;
        end
    end

    // ==========================================================
    // Enable registers, edge history, read data
    always @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            sys_en_q <= `WECS_EN_RESET;
            trx_en_q <= `WECS_EN_RESET;
            bf_en_q <= `WECS_EN_RESET;
            wk_en_q <= `WECS_EN_RESET;
            por_q <= 1'b1;
            battery_prev_q <= 1'b1;
            wake_prev_q <= 1'b0;
            wake_prev_valid_q <= 1'b0;
            temp_prev_q <= 1'b0;
            REG_RDATA_O <= `WECS_ZERO_BYTE;
        end else begin
            por_q <= 1'b0;
            battery_prev_q <= BATTERY_SUPPLY_OK_I;
            wake_prev_q <= WAKE_PIN_I;
            wake_prev_valid_q <= 1'b1;
            temp_prev_q <= TEMP_WARN_I;
            if (wr_sys_en) begin
                sys_en_q <= REG_WDATA_I & `WECS_SYS_EN_MASK;
            end
            if (wr_trx_en) begin
                trx_en_q <= REG_WDATA_I & `WECS_TRX_EN_MASK;
            end
            if (wr_bf_en) begin
                bf_en_q <= REG_WDATA_I & `WECS_BF_EN_MASK;
            end
            if (wr_wk_en) begin
                wk_en_q <= REG_WDATA_I & `WECS_WK_EN_MASK;
            end
            if (REG_RD_I) begin
                case (REG_ADDR_I)
                    `WECS_ADDR_SYS_EN: REG_RDATA_O <= sys_en_q;
                    `WECS_ADDR_TRX_EN: REG_RDATA_O <= trx_en_q;
                    `WECS_ADDR_BF_EN: REG_RDATA_O <= bf_en_q;
                    `WECS_ADDR_WK_EN: REG_RDATA_O <= wk_en_q;
                    `WECS_ADDR_SUMMARY: REG_RDATA_O <= summary;
                    `WECS_ADDR_SYS_ST: REG_RDATA_O <= sys_st;
                    `WECS_ADDR_TRX_ST: REG_RDATA_O <= trx_st;
                    `WECS_ADDR_WK_ST: REG_RDATA_O <= wk_st;
                    `WECS_ADDR_BF_ST: REG_RDATA_O <= bf_st;
                    `WECS_ADDR_DEV_ID: REG_RDATA_O <= DEVICE_IDENTIFICATION;
                    default: REG_RDATA_O <= `WECS_ZERO_BYTE;
                endcase
            end
        end
    end
endmodule

// file: sim/wecs_top_properties.sv
// Checker of the wake and event capture block, bound to its top module.
// Assumes it sees only the top ports; the delay length is handed on by the bind.
`timescale 1ns/1ns

module wecs_chk #(
    parameter EVENT_DELAY_CYCLES = 1000,
    parameter [7:0] DEVICE_IDENTIFICATION = 8'h5a
) (
    input wire SYS_CLK_I,
    input wire RESET_I,
    input wire [6:0] REG_ADDR_I,
    input wire REG_RD_I,
    input wire MODE_REQ_VALID_I,
    input wire [2:0] MODE_REQ_I,
    input wire IO_SUPPLY_OK_I,
    input wire [7:0] REG_RDATA_O,
    input wire [2:0] DEVICE_MODE_O,
    input wire RXD_LOW_O,
    input wire INHIBIT_O
);
    // ==========================================================
    // Release window after a clearing write
    localparam [15:0] HOLD = EVENT_DELAY_CYCLES - 1;
    reg [15:0] hold_q;

    default clocking dcb @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);

    // Only a clear can drop the alert with supply up outside normal mode
    always @(posedge SYS_CLK_I) begin
        if (RESET_I)
            hold_q <= 16'h0000;
        else if ($fell(RXD_LOW_O) && IO_SUPPLY_OK_I && $past(IO_SUPPLY_OK_I) &&
                 DEVICE_MODE_O != 3'h7 && $past(DEVICE_MODE_O) != 3'h7)
            hold_q <= HOLD;
        else if (hold_q != 16'h0000)
            hold_q <= hold_q - 16'h0001;
    end

    // ==========================================================
    // Assertions
    sequence rel_s;
        $fell(RESET_I) ##0 IO_SUPPLY_OK_I [*3];
    endsequence

    por_alert_a: assert property (rel_s |-> ##[0:2] RXD_LOW_O)
        else $error("no alert after power-on");
    rxd_hold_a: assert property (hold_q != 16'h0000 |-> !RXD_LOW_O)
        else $error("alert back before delay ran out");
    rxd_io_a: assert property (!IO_SUPPLY_OK_I |=> !RXD_LOW_O)
        else $error("alert without io supply");
    inh_mode_a: assert property (INHIBIT_O == (DEVICE_MODE_O != 3'h1))
        else $error("inhibit does not follow sleep");
    sleep_gate_a: assert property (MODE_REQ_VALID_I && MODE_REQ_I == 3'h1 && RXD_LOW_O |=> DEVICE_MODE_O == 3'h4)
        else $error("sleep taken with pending event");
    stby_req_a: assert property (MODE_REQ_VALID_I && MODE_REQ_I == 3'h4 |=> DEVICE_MODE_O == 3'h4)
        else $error("standby request not taken");
    bad_mode_a: assert property (MODE_REQ_VALID_I && !(MODE_REQ_I inside {3'h1, 3'h4, 3'h7}) &&
        DEVICE_MODE_O != 3'h1 |=> $stable(DEVICE_MODE_O)) else $error("illegal mode code changed mode");
    wake_exit_a: assert property ($past(DEVICE_MODE_O) == 3'h1 && DEVICE_MODE_O != 3'h1 &&
        !$past(MODE_REQ_VALID_I) |-> DEVICE_MODE_O == 3'h4) else $error("sleep left to wrong mode");
    id_read_a: assert property (REG_RD_I && REG_ADDR_I == 7'h7e |=> REG_RDATA_O == DEVICE_IDENTIFICATION)
        else $error("device_identification read mismatch");
    rd_hold_a: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
        else $error("read data moved without read");
endmodule

bind wecs_top wecs_chk #(.EVENT_DELAY_CYCLES(EVENT_DELAY_CYCLES), .DEVICE_IDENTIFICATION(DEVICE_IDENTIFICATION)) wecs_chk_inst (.*);

// file: sim/wecs_host.sv
// Host model: register port master and mode requester of the block.
// Assumes the bench calls its tasks; strobes change at the falling edge.
`timescale 1ns/1ns

module wecs_host (
    input wire SYS_CLK_I,
    input wire [7:0] REG_RDATA_O,
    output reg [6:0] REG_ADDR_I = 7'h00,
    output reg REG_WR_I = 1'b0,
    output reg REG_RD_I = 1'b0,
    output reg [7:0] REG_WDATA_I = 8'h00,
    output reg MODE_REQ_VALID_I = 1'b0,
    output reg [2:0] MODE_REQ_I = 3'h0
);
    // ==========================================================
    // Kind 0 write, 1 read, 2 mode request; one access per call
    task xfer(input [1:0] k, input [6:0] a, input [7:0] d);
        @(negedge SYS_CLK_I);
        REG_ADDR_I <= a;
        REG_WDATA_I <= d;
        MODE_REQ_I <= d[2:0];
        REG_WR_I <= k == 2'd0;
        REG_RD_I <= k == 2'd1;
        MODE_REQ_VALID_I <= k == 2'd2;
        @(negedge SYS_CLK_I);
        {REG_WR_I, REG_RD_I, MODE_REQ_VALID_I} <= 3'b000;
        // Idle lines flip so a stale value is never mistaken for a request
        REG_ADDR_I <= ~a;
        REG_WDATA_I <= ~d;
    endtask

    // Clears exactly what was read set, so late events survive
    task clr(input [6:0] a);
        reg [7:0] d;
        xfer(2'd1, a, 8'h00);
        d = REG_RDATA_O;
        xfer(2'd0, a, d);
    endtask
endmodule

// file: sim/tb_top.sv
// Self-checking bench of the wake and event capture block.
// Assumes the host model drives the register port; events come from here.
`timescale 1ns/1ns
`include "wecs_defines.vh"
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin fail_count++; \
$display("Error %s expected %h seen %h", n, e, s); end end

module tb_top;
    localparam EDC = 8;
    localparam [7:0] ID = 8'h3c;
    localparam [79:0] EXP_T = 80'h02_02_01_02_01_01_01_08_20_10;
    reg SYS_CLK_I = 1'b0;
    reg RESET_I = 1'b1;
    reg [9:0] pv = 10'h000;
    reg WAKE_PIN_I = 1'b0, TEMP_WARN_I = 1'b0, BATTERY_SUPPLY_OK_I = 1'b1, IO_SUPPLY_OK_I = 1'b1;
    reg TRX_STANDBY_I = 1'b1, TRX_ACTIVE_I = 1'b1;
    reg [1:0] TRX_MODE_SELECT_I = 2'b01;
    reg [5:0] SPI_CLK_COUNT_I = 6'd17;
    wire BUS_WAKE_I, FRAME_ERR_OVF_I, BUS_SILENCE_I, TXD_DOM_TIMEOUT_I, VCC_UNDERVOLT_I;
    wire RXD_REC_CLAMP_I, BUS_DOM_TIMEOUT_I, BUS_REC_CLAMP_I, SPI_FRAME_DONE_I, LOCKED_WRITE_I;
    wire [6:0] REG_ADDR_I;
    wire REG_WR_I, REG_RD_I, MODE_REQ_VALID_I, RXD_LOW_O, INHIBIT_O;
    wire [7:0] REG_WDATA_I, REG_RDATA_O;
    wire [2:0] MODE_REQ_I, DEVICE_MODE_O;
    reg [7:0] exp_q [$];
    reg [7:0] e, r, m;
    reg [6:0] a;
    reg rd_seen = 1'b0;
    reg [31:0] seed = 32'h5297e2e9;
    integer i, fail_count = 0, n_checks = 0;

    assign {LOCKED_WRITE_I, SPI_FRAME_DONE_I, BUS_REC_CLAMP_I, BUS_DOM_TIMEOUT_I, RXD_REC_CLAMP_I,
            VCC_UNDERVOLT_I, TXD_DOM_TIMEOUT_I, BUS_SILENCE_I, FRAME_ERR_OVF_I, BUS_WAKE_I} = pv;
    always #2 SYS_CLK_I = ~SYS_CLK_I;

    wecs_top #(.EVENT_DELAY_CYCLES(EDC), .DEVICE_IDENTIFICATION(ID)) wecs_top_inst (.*);
    wecs_host wecs_host_inst (.*);

    // ==========================================================
    // Read results are compared in order against the notes
    always @(posedge SYS_CLK_I) rd_seen <= REG_RD_I;
    always @(negedge SYS_CLK_I) begin
        if (rd_seen) begin
            e = exp_q.pop_front();
            `CHK("read data", e, REG_RDATA_O)
        end
    end

    // ==========================================================
    // Tasks
    task cyc(input integer n);
        repeat (n) @(negedge SYS_CLK_I);
    endtask
    task wr(input [6:0] ad, input [7:0] d);
        wecs_host_inst.xfer(2'd0, ad, d);
    endtask
    task rd(input [6:0] ad, input [7:0] x);
        exp_q.push_back(x);
        wecs_host_inst.xfer(2'd1, ad, 8'h00);
    endtask
    task clr(input [6:0] ad, input [7:0] x);
        exp_q.push_back(x);
        wecs_host_inst.clr(ad);
    endtask
    task md(input [2:0] mc);
        wecs_host_inst.xfer(2'd2, 7'h00, {5'h00, mc});
    endtask
    task pulse(input [9:0] v);
        @(negedge SYS_CLK_I);
        pv = v;
        @(negedge SYS_CLK_I);
        pv = 10'h000;
    endtask
    task wpin;
        WAKE_PIN_I = 1'b1;
        cyc(2);
        WAKE_PIN_I = 1'b0;
        cyc(2);
    endtask
    task en_all(input integer zero);
        for (i = 0; i < 4; i++) begin
            {a, m} = en_reg(i);
            wr(a, zero ? 8'h00 : m);
        end
    endtask
    function [14:0] en_reg(input integer k);
        case (k)
            0: en_reg = {`WECS_ADDR_SYS_EN, `WECS_SYS_EN_MASK};
            1: en_reg = {`WECS_ADDR_TRX_EN, `WECS_TRX_EN_MASK};
            2: en_reg = {`WECS_ADDR_BF_EN, `WECS_BF_EN_MASK};
            default: en_reg = {`WECS_ADDR_WK_EN, `WECS_WK_EN_MASK};
        endcase
    endfunction
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (5000) @(negedge SYS_CLK_I);
        fail_count++;
        print_verdict;
    end

    // ==========================================================
    // Main sequence
    initial begin
        cyc(10);
        RESET_I = 1'b0;
        cyc(4);
        `CHK("alert", 1'b1, RXD_LOW_O)
        rd(`WECS_ADDR_SYS_ST, 8'h10);
        rd(`WECS_ADDR_SUMMARY, 8'h01);
        wr(`WECS_ADDR_DEV_ID, 8'hff);
        rd(`WECS_ADDR_DEV_ID, ID);
        rd(7'h10, 8'h00);
        rd(`WECS_ADDR_WK_EN, 8'h00);
        rd(`WECS_ADDR_TRX_EN, 8'h00);
        $display("test 1 done");
        for (i = 0; i < 4; i++) begin
            {a, m} = en_reg(i);
            r = $random(seed);
            wr(a, r);
            rd(a, r & m);
        end
        en_all(0);
        $display("test 2 done");
        clr(`WECS_ADDR_SYS_ST, 8'h10);
        `CHK("alert", 1'b0, RXD_LOW_O)
        pulse(10'h005);
        cyc(2);
        `CHK("alert", 1'b0, RXD_LOW_O)
        cyc(EDC);
        `CHK("alert", 1'b1, RXD_LOW_O)
        clr(`WECS_ADDR_TRX_ST, 8'h18);
        cyc(EDC + 2);
        `CHK("alert", 1'b0, RXD_LOW_O)
        $display("test 3 done");
        en_all(1);
        pulse(10'h3ff);
        wpin;
        rd(`WECS_ADDR_TRX_ST, 8'h20);
        rd(`WECS_ADDR_SYS_ST, 8'h00);
        rd(`WECS_ADDR_BF_ST, 8'h00);
        rd(`WECS_ADDR_WK_ST, 8'h00);
        clr(`WECS_ADDR_TRX_ST, 8'h20);
        BATTERY_SUPPLY_OK_I = 1'b0;
        cyc(2);
        BATTERY_SUPPLY_OK_I = 1'b1;
        cyc(2);
        clr(`WECS_ADDR_SYS_ST, 8'h10);
        $display("test 4 done");
        en_all(0);
        for (i = 0; i < 10; i++) begin
            pulse(10'h001 << i);
            a = i > 7 ? `WECS_ADDR_SYS_ST : (i > 5 ? `WECS_ADDR_BF_ST : `WECS_ADDR_TRX_ST);
            rd(`WECS_ADDR_SUMMARY, i > 7 ? 8'h01 : (i > 5 ? 8'h04 : 8'h02));
            clr(a, EXP_T[i * 8 +: 8]);
        end
        wpin;
        rd(`WECS_ADDR_SUMMARY, 8'h08);
        clr(`WECS_ADDR_WK_ST, 8'h03);
        for (i = 16; i < 33; i += 8) begin
            SPI_CLK_COUNT_I = i[5:0];
            pulse(10'h100);
        end
        TRX_MODE_SELECT_I = 2'b10;
        TRX_ACTIVE_I = 1'b0;
        pulse(10'h030);
        wpin;
        TEMP_WARN_I = 1'b1;
        cyc(2);
        TEMP_WARN_I = 1'b0;
        rd(`WECS_ADDR_SYS_ST, 8'h00);
        rd(`WECS_ADDR_TRX_ST, 8'h00);
        clr(`WECS_ADDR_WK_ST, 8'h03);
        md(3'h7);
        TEMP_WARN_I = 1'b1;
        TRX_STANDBY_I = 1'b0;
        cyc(EDC + 2);
        `CHK("alert", 1'b0, RXD_LOW_O)
        TRX_STANDBY_I = 1'b1;
        cyc(2);
        `CHK("alert", 1'b1, RXD_LOW_O)
        clr(`WECS_ADDR_SYS_ST, 8'h04);
        md(3'h2);
        `CHK("mode", 3'h7, DEVICE_MODE_O)
        clr(`WECS_ADDR_SYS_ST, 8'h02);
        md(3'h4);
        $display("test 5 done");
        pulse(10'h001);
        cyc(EDC + 2);
        md(3'h1);
        `CHK("mode", 3'h4, DEVICE_MODE_O)
        clr(`WECS_ADDR_TRX_ST, 8'h10);
        md(3'h1);
        `CHK("mode", 3'h1, DEVICE_MODE_O)
        pulse(10'h001);
        cyc(1);
        `CHK("mode", 3'h4, DEVICE_MODE_O)
        `CHK("inhibit", 1'b1, INHIBIT_O)
        cyc(EDC);
        `CHK("alert", 1'b1, RXD_LOW_O)
        clr(`WECS_ADDR_TRX_ST, 8'h10);
        IO_SUPPLY_OK_I = 1'b0;
        md(3'h1);
        wpin;
        `CHK("inhibit", 1'b1, INHIBIT_O)
        `CHK("alert", 1'b0, RXD_LOW_O)
        IO_SUPPLY_OK_I = 1'b1;
        clr(`WECS_ADDR_WK_ST, 8'h03);
        wr(`WECS_ADDR_TRX_EN, 8'h09);
        wr(`WECS_ADDR_WK_EN, 8'h00);
        md(3'h1);
        `CHK("mode", 3'h4, DEVICE_MODE_O)
        $display("test 6 done");
        print_verdict;
    end
endmodule
